// ---- dv/msa_attr_readout_tb.sv ----
`timescale 1ns/100ps
module msa_attr_readout_tb;
	import msa_attr_pkg::*;
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic [11:0] i_addr = 12'h0;
	logic [31:0] i_wdata = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [31:0] o_rdata;
	logic i_s3_valid = 1'b0;
	logic i_s4_valid = 1'b0;
	msa_attr_s3_t i_s3_attr = '0;
	msa_attr_s4_t i_s4_attr = '0;
	msa_attr_s3_t e3;
	msa_attr_s4_t e4;
	logic [31:0] seed = 32'h2ef8;
	logic [31:0] exp_q[$];
	logic [11:0] adr_q[$];
	logic rd_p = 1'b0;
	int num_errors = 0;
	int total_checks = 0;
	// last entry is an unmapped hole inside the bank
	localparam logic [11:0] OFS [19] = '{MSA_OFS_VSW3, MSA_OFS_VST3,
		MSA_OFS_VTOT3, MSA_OFS_FMTA3, MSA_OFS_FMTB3, MSA_OFS_CRM3,
		MSA_OFS_CRN3, MSA_OFS_VBID3, MSA_OFS_HRES4, MSA_OFS_HPOL4,
		MSA_OFS_HSW4, MSA_OFS_HST4, MSA_OFS_HTOT4, MSA_OFS_VACT4,
		MSA_OFS_VPOL4, MSA_OFS_VSW4, MSA_OFS_VST4, MSA_OFS_VTOT4, 12'h5bc};

	always #20 i_clk = ~i_clk;

	msa_attr_readout msa_attr_readout_inst (.i_clk(i_clk),
		.i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_s3_valid(i_s3_valid), .i_s3_attr(i_s3_attr),
		.i_s4_valid(i_s4_valid), .i_s4_attr(i_s4_attr));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic [31:0] expect_of(input logic [11:0] a);
		case (a)
			MSA_OFS_VSW3: return {17'h0, e3.vsync_width};
			MSA_OFS_VST3: return {16'h0, e3.vert_start};
			MSA_OFS_VTOT3: return {16'h0, e3.vert_total};
			MSA_OFS_FMTA3: return {24'h0, e3.format_attr_a};
			MSA_OFS_FMTB3: return {24'h0, e3.format_attr_b & 8'h87};
			MSA_OFS_CRM3: return {8'h0, e3.clk_recovery_m};
			MSA_OFS_CRN3: return {8'h0, e3.clk_recovery_n};
			MSA_OFS_VBID3: return {24'h0, e3.blanking_id};
			MSA_OFS_HRES4: return {16'h0, e4.horiz_res};
			MSA_OFS_HPOL4: return {31'h0, e4.hsync_polarity};
			MSA_OFS_HSW4: return {17'h0, e4.hsync_width};
			MSA_OFS_HST4: return {16'h0, e4.horiz_start};
			MSA_OFS_HTOT4: return {16'h0, e4.horiz_total};
			MSA_OFS_VACT4: return {16'h0, e4.active_lines};
			MSA_OFS_VPOL4: return {31'h0, e4.vsync_polarity};
			MSA_OFS_VSW4: return {17'h0, e4.vsync_width};
			MSA_OFS_VST4: return {16'h0, e4.vert_start};
			MSA_OFS_VTOT4: return {16'h0, e4.vert_total};
			default: return 32'h0;
		endcase
	endfunction : expect_of

	task automatic chk(input string nm, input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up

	// strobes are left up; the next task or idle lowers them
	task automatic rd(input logic [11:0] a);
		exp_q.push_back(expect_of(a));
		adr_q.push_back(a);
		i_rd <= 1'b1;
		i_wr <= 1'b0;
		i_addr <= a;
		@(posedge i_clk);
	endtask : rd

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		i_wr <= 1'b1;
		i_rd <= 1'b0;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
	endtask : wr

	task automatic sweep();
		for (int k = 0; k < 19; k++) begin
			wr(OFS[k], rnd());
			rd(OFS[k]);
		end
		i_rd <= 1'b0;
		i_wr <= 1'b0;
		repeat (3) @(posedge i_clk);
	endtask : sweep

	task automatic reset_dut();
		e3 = '0;
		e3.blanking_id = MSA_VBID_RST;
		e4 = '0;
		i_reset_n <= 1'b0;
		repeat (20) @(posedge i_clk);
		i_reset_n <= 1'b1;
		@(posedge i_clk);
	endtask : reset_dut

	// the payload is scrambled once valid drops: only the rise may capture
	task automatic pkt(input logic s3, input logic s4);
		logic [159:0] t;
		t = {rnd(), rnd(), rnd(), rnd(), rnd()};
		if (s3) begin
			i_s3_attr <= t[118:0];
			e3 = t[118:0];
		end
		if (s4) begin
			i_s4_attr <= t[159:32];
			e4 = t[159:32];
		end
		i_s3_valid <= s3;
		i_s4_valid <= s4;
		repeat (6) @(posedge i_clk);
		i_s3_valid <= 1'b0;
		i_s4_valid <= 1'b0;
		i_s3_attr <= ~t[118:0];
		i_s4_attr <= ~t[127:0];
		repeat (5) @(posedge i_clk);
	endtask : pkt

	// read data stand only in the cycle after the strobe was sampled
	always @(posedge i_clk) begin
		rd_p <= i_rd;
	end

	always @(negedge i_clk) begin
		logic [31:0] ev;
		logic [11:0] ea;
		ev = 32'h0;
		ea = 12'h0;
		if (rd_p === 1'b1) begin
			ev = exp_q.pop_front();
			ea = adr_q.pop_front();
			chk($sformatf("rdata at %h", ea), o_rdata, ev);
		end
	end

	initial begin
		reset_dut();
		sweep();
		for (int r = 0; r < 3; r++) begin
			pkt(r != 1, r != 2);
			sweep();
		end
		reset_dut();
		sweep();
		wrap_up();
	end

	initial begin
		#200000;
		num_errors++;
		wrap_up();
	end
endmodule : msa_attr_readout_tb

// ---- hw/msa_attr_pkg.sv ----
package msa_attr_pkg;
	localparam int unsigned MSA_AW = 12;
	localparam logic [11:0] MSA_OFS_VSW3 = 12'h59c;
	localparam logic [11:0] MSA_OFS_VST3 = 12'h5a0;
	localparam logic [11:0] MSA_OFS_VTOT3 = 12'h5a4;
	localparam logic [11:0] MSA_OFS_FMTA3 = 12'h5a8;
	localparam logic [11:0] MSA_OFS_FMTB3 = 12'h5ac;
	localparam logic [11:0] MSA_OFS_CRM3 = 12'h5b0;
	localparam logic [11:0] MSA_OFS_CRN3 = 12'h5b4;
	localparam logic [11:0] MSA_OFS_VBID3 = 12'h5b8;
	localparam logic [11:0] MSA_OFS_HRES4 = 12'h5c0;
	localparam logic [11:0] MSA_OFS_HPOL4 = 12'h5c4;
	localparam logic [11:0] MSA_OFS_HSW4 = 12'h5c8;
	localparam logic [11:0] MSA_OFS_HST4 = 12'h5cc;
	localparam logic [11:0] MSA_OFS_HTOT4 = 12'h5d0;
	localparam logic [11:0] MSA_OFS_VACT4 = 12'h5d4;
	localparam logic [11:0] MSA_OFS_VPOL4 = 12'h5d8;
	localparam logic [11:0] MSA_OFS_VSW4 = 12'h5dc;
	localparam logic [11:0] MSA_OFS_VST4 = 12'h5e0;
	localparam logic [11:0] MSA_OFS_VTOT4 = 12'h5e4;
	localparam logic [7:0] MSA_VBID_RST = 8'h19;
	localparam logic [7:0] MSA_FMTB_RSVD_MASK = 8'h87;
	localparam int unsigned MSA_SYNC_STAGES = 2;

	typedef struct packed {
		logic [14:0] vsync_width;
		logic [15:0] vert_start;
		logic [15:0] vert_total;
		logic [7:0] format_attr_a;
		logic [7:0] format_attr_b;
		logic [23:0] clk_recovery_m;
		logic [23:0] clk_recovery_n;
		logic [7:0] blanking_id;
	} msa_attr_s3_t;

	typedef struct packed {
		logic [15:0] horiz_res;
		logic hsync_polarity;
		logic [14:0] hsync_width;
		logic [15:0] horiz_start;
		logic [15:0] horiz_total;
		logic [15:0] active_lines;
		logic vsync_polarity;
		logic [14:0] vsync_width;
		logic [15:0] vert_start;
		logic [15:0] vert_total;
	} msa_attr_s4_t;

	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} msa_attr_req_t;
endpackage : msa_attr_pkg

// ---- hw/msa_attr_readout.sv ----
`timescale 1ns/100ps
module msa_attr_readout
	import msa_attr_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// register port
	input wire logic [11:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// decoded attributes, stream 3
	input wire logic i_s3_valid,
	input wire msa_attr_s3_t i_s3_attr,
	// decoded attributes, stream 4
	input wire logic i_s4_valid,
	input wire msa_attr_s4_t i_s4_attr
);
	msa_attr_s3_t s3_q;
	msa_attr_s4_t s4_q;
	logic s3_load;
	logic s4_load;
	logic [31:0] rdata_d;
	msa_attr_req_t req;

	// the attribute payload is quasi-static: it is only sampled on the
	// synchronised packet pulse, long after the decoder settled it
	msa_attr_upd u_s3_upd (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_valid(i_s3_valid),
		.o_load(s3_load)
	);

	msa_attr_upd u_s4_upd (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_valid(i_s4_valid),
		.o_load(s4_load)
	);

	assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s3_q <= '0;
			s3_q.blanking_id <= MSA_VBID_RST;
		end else if (s3_load) begin
			s3_q <= i_s3_attr;
			s3_q.format_attr_b <= i_s3_attr.format_attr_b &
				MSA_FMTB_RSVD_MASK;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s4_q <= '0;
		end else if (s4_load) begin
			s4_q <= i_s4_attr;
		end
	end

	// write strobe and data deliberately unused: every location is read-only
	always_comb begin
		rdata_d = 32'h0;
		if (req.rd) begin
			unique case (req.addr)
				MSA_OFS_VSW3: rdata_d = {17'h0, s3_q.vsync_width};
				MSA_OFS_VST3: rdata_d = {16'h0, s3_q.vert_start};
				MSA_OFS_VTOT3: rdata_d = {16'h0, s3_q.vert_total};
				MSA_OFS_FMTA3: rdata_d = {24'h0, s3_q.format_attr_a};
				MSA_OFS_FMTB3: rdata_d = {24'h0, s3_q.format_attr_b};
				MSA_OFS_CRM3: rdata_d = {8'h0, s3_q.clk_recovery_m};
				MSA_OFS_CRN3: rdata_d = {8'h0, s3_q.clk_recovery_n};
				MSA_OFS_VBID3: rdata_d = {24'h0, s3_q.blanking_id};
				MSA_OFS_HRES4: rdata_d = {16'h0, s4_q.horiz_res};
				MSA_OFS_HPOL4: rdata_d = {31'h0, s4_q.hsync_polarity};
				MSA_OFS_HSW4: rdata_d = {17'h0, s4_q.hsync_width};
				MSA_OFS_HST4: rdata_d = {16'h0, s4_q.horiz_start};
				MSA_OFS_HTOT4: rdata_d = {16'h0, s4_q.horiz_total};
				MSA_OFS_VACT4: rdata_d = {16'h0, s4_q.active_lines};
				MSA_OFS_VPOL4: rdata_d = {31'h0, s4_q.vsync_polarity};
				MSA_OFS_VSW4: rdata_d = {17'h0, s4_q.vsync_width};
				MSA_OFS_VST4: rdata_d = {16'h0, s4_q.vert_start};
				MSA_OFS_VTOT4: rdata_d = {16'h0, s4_q.vert_total};
				default: rdata_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata <= 32'h0;
		end else begin
			o_rdata <= rdata_d;
		end
	end

	property p_vbid_reset;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_rd && i_addr == MSA_OFS_VBID3 && s3_q.blanking_id == MSA_VBID_RST)
			|=> (o_rdata == 32'h19);
	endproperty
	a_vbid_reset: assert property (p_vbid_reset)
		else $error("blanking id readback wrong");

	property p_fmtb_rsvd;
		@(posedge i_clk) disable iff (!i_reset_n)
		$past(i_rd && i_addr == MSA_OFS_FMTB3) |-> (o_rdata[6:3] == 4'h0);
	endproperty
	a_fmtb_rsvd: assert property (p_fmtb_rsvd)
		else $error("reserved format bits not zero");

	sequence s_s3_pulse;
		$rose(i_s3_valid) ##3 1'b1;
	endsequence
	property p_s3_update;
		@(posedge i_clk) disable iff (!i_reset_n)
		(s_s3_pulse and (i_s3_valid [*4])) |=>
			(s3_q.clk_recovery_m == $past(i_s3_attr.clk_recovery_m));
	endproperty
	a_s3_update: assert property (p_s3_update)
		else $error("stream 3 attributes not captured");

	property p_no_write_effect;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_wr && !s4_load) |=> $stable(s4_q);
	endproperty
	a_no_write_effect: assert property (p_no_write_effect)
		else $error("write changed a read-only register");

	property p_crn_read;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_rd && i_addr == MSA_OFS_CRN3 && !s3_load) |=>
			(o_rdata == {8'h0, s3_q.clk_recovery_n});
	endproperty
	a_crn_read: assert property (p_crn_read)
		else $error("clock recovery N readback wrong");

	property p_vpol_read;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_rd && i_addr == MSA_OFS_VPOL4 && !s4_load) |=>
			(o_rdata == {31'h0, s4_q.vsync_polarity});
	endproperty
	a_vpol_read: assert property (p_vpol_read)
		else $error("vsync polarity readback wrong");

	property p_hsw_read;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_rd && i_addr == MSA_OFS_HSW4 && !s4_load) |=>
			(o_rdata[31:15] == 17'h0 && o_rdata[14:0] == s4_q.hsync_width);
	endproperty
	a_hsw_read: assert property (p_hsw_read)
		else $error("hsync width readback wrong");

	property p_idle_zero;
		@(posedge i_clk) disable iff (!i_reset_n)
		!i_rd |=> (o_rdata == 32'h0);
	endproperty
	a_idle_zero: assert property (p_idle_zero)
		else $error("read data not zero outside a read");
endmodule : msa_attr_readout

// ---- hw/msa_attr_upd.sv ----
`timescale 1ns/100ps
// two-stage synchroniser on the decoder's packet-valid level, then a
// rising-edge pulse; the payload is assumed stable while valid is high
module msa_attr_upd
	import msa_attr_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// level from the link decoder
	input wire logic i_valid,
	// one-cycle capture pulse
	output logic o_load
);
	logic [MSA_SYNC_STAGES-1:0] sync_q;
	logic seen_q;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync_q <= '0;
		end else begin
			sync_q <= {sync_q[0], i_valid};
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			seen_q <= 1'b0;
			o_load <= 1'b0;
		end else begin
			seen_q <= sync_q[1];
			o_load <= sync_q[1] & ~seen_q;
		end
	end
endmodule : msa_attr_upd
